// >>> logic/dcl_line_ctrl.v
// Purpose: Line-state control of a four-way operand data cache.
// Assumes: 16 sets, 4 long words a line, requests held until acknowledged.
// Notes:   Snoops are taken only while the memory bus is idle.
// How it works
// RQ1: Lines are invalid, valid or dirty.
// RQ2: Page cache mode picks copyback or write-through.
// RQ3: Read and copyback write misses fill a line.
// RQ4: Invalid way first, else a pseudo-random way.
// RQ5: Read fill leaves the way valid.
// RQ6: Dirty victim buffered, pushed after the fill.
// RQ7: Snoops also check the push buffer.
// RQ8: Read hits answer from cache, state kept.
// RQ9: Write-through write miss goes to memory only.
// RQ10: Copyback writes set word flags and line dirty.
// RQ11: Write-through hit updates line and memory, flags kept.
// RQ12: Invalidate drops lines without memory writes.
// RQ13: Push writes dirty data back, then invalidates.
// RQ14: Snoop read, code 01, valid line: no action.
// RQ15: Snoop read, code 01, dirty line: inhibit, source data.
// RQ16: Snoop read, code 10: source if dirty, invalidate.
// RQ17: Snoop write, code 10: invalidate, no data.
// RQ18: Snoop part-line write, code 01: dirty sinks, else invalidate.
// RQ19: Software avoids write-through access to dirty lines.
// RQ20: Dirty-victim refill: valid for reads, dirty for writes.
// RQ21: One dirty word pushes single; two or more burst.
// RQ22: Pushes carry transfer modifier code zero.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`include "dcl_consts.vh"

module dcl_line_ctrl (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// Integer unit requests
	input  wire        iu_req,
	input  wire        iu_we,
	input  wire [31:0] iu_addr,
	input  wire [31:0] iu_wdata,
	input  wire        page_cache_mode,
	output wire        iu_ack,
	output wire [31:0] iu_rdata,
	// Cache commands
	input  wire        cache_invalidate_cmd,
	input  wire        cache_writeback_cmd,
	input  wire [31:0] cmd_addr,
	output wire        cmd_ack,
	// Memory bus
	output wire        mem_req,
	output wire        mem_we,
	output wire        mem_burst,
	output wire [31:0] mem_addr,
	output wire [31:0] mem_wdata,
	output wire [2:0]  transfer_modifier_code,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	// Snoop port
	input  wire        snp_valid,
	input  wire        snp_we,
	input  wire        snp_line,
	input  wire [1:0]  snoop_control_code,
	input  wire [31:0] snp_addr,
	input  wire [31:0] snp_wdata,
	output wire        snp_ack,
	output wire        memory_response_inhibit,
	output wire [31:0] snp_rdata,
	// AXI4-Lite registers
	input  wire        awvalid,
	output wire        awready,
	input  wire [11:0] awaddr,
	input  wire        wvalid,
	output wire        wready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	output wire        bvalid,
	input  wire        bready,
	output wire [1:0]  bresp,
	input  wire        arvalid,
	output wire        arready,
	input  wire [11:0] araddr,
	output wire        rvalid,
	input  wire        rready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp
);

	localparam S_IDLE  = 3'd0;
	localparam S_FILL  = 3'd1;
	localparam S_WT    = 3'd2;
	localparam S_RDMEM = 3'd3;
	localparam S_PEND  = 3'd4;
	localparam S_PUSH  = 3'd5;

	// Line state, word dirty flags, tags, data
	reg [1:0]  lst_r [0:63];
	reg [3:0]  word_dirty_flags [0:63];
	reg [23:0] tag_r [0:63];
	reg [31:0] dat_r [0:255];
	// Push buffer
	reg        pb_vld_r;
	reg [27:0] pb_addr_r;
	reg [3:0]  pb_fl_r;
	reg [31:0] pb_dat_r [0:3];

	reg [2:0]  st_r;
	reg [1:0]  beat_r;
	reg [1:0]  slot_r;
	reg [31:0] rq_addr_r;
	reg [31:0] rq_data_r;
	reg        rq_we_r;
	reg [7:0]  lfsr_r;
	reg [31:0] hit_cnt_r;
	reg [31:0] miss_cnt_r;
	reg        iu_ack_r;
	reg [31:0] iu_rdata_r;
	reg        cmd_ack_r;
	reg        mem_req_r;
	reg        mem_we_r;
	reg        mem_burst_r;
	reg [31:0] mem_addr_r;
	reg [31:0] mem_wdata_r;
	reg [2:0]  tm_r;
	reg        snp_ack_r;
	reg        mi_r;
	reg [31:0] snp_rdata_r;
	wire       ctrl_en;
	integer    i;

	function [3:0] hitv;
		input [31:0] a;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				hitv[k] = (lst_r[a[7:4] * 4 + k] != `DCL_ST_INV) &&
					(tag_r[a[7:4] * 4 + k] == a[31:8]);
		end
	endfunction

	function [1:0] enc4;
		input [3:0] v;
		begin
			enc4 = v[3] ? 2'd3 : v[2] ? 2'd2 : v[1] ? 2'd1 : 2'd0;
		end
	endfunction

	wire [3:0] iu_hit = hitv(iu_addr);
	wire [5:0] iu_li  = {iu_addr[7:4], enc4(iu_hit)};
	wire [3:0] iu_bit = 4'h1 << iu_addr[3:2];
	wire [3:0] inv_v;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_inv
			assign inv_v[g] = lst_r[iu_addr[7:4] * 4 + g] == `DCL_ST_INV;
		end
	endgenerate
	wire [1:0] vict = (|inv_v) ? enc4(inv_v) : lfsr_r[1:0]; // see RQ4
	wire [5:0] v_li = {iu_addr[7:4], vict};

	wire [3:0] cm_hit = hitv(cmd_addr);
	wire [5:0] cm_li  = {cmd_addr[7:4], enc4(cm_hit)};
	wire [3:0] sn_hit = hitv(snp_addr);
	wire [5:0] sn_li  = {snp_addr[7:4], enc4(sn_hit)};
	wire [3:0] sn_bit = 4'h1 << snp_addr[3:2];
	wire [1:0] sn_st  = lst_r[sn_li];
	wire       sn_pb  = pb_vld_r && pb_addr_r == snp_addr[31:4];
	wire       sn_inv = snoop_control_code == `DCL_SC_INVAL;
	wire       sn_lv  = snoop_control_code == `DCL_SC_LEAVE;
	wire       snp_go = snp_valid && !snp_ack_r &&
		(st_r == S_IDLE || st_r == S_PEND);
	wire       pb_multi = (pb_fl_r & (pb_fl_r - 4'h1)) != 4'h0;
	wire [1:0] pb_one   = enc4(pb_fl_r);
	wire [5:0] fl_li    = {rq_addr_r[7:4], slot_r};

	assign iu_ack = iu_ack_r;
	assign iu_rdata = iu_rdata_r;
	assign cmd_ack = cmd_ack_r;
	assign mem_req = mem_req_r;
	assign mem_we = mem_we_r;
	assign mem_burst = mem_burst_r;
	assign mem_addr = mem_addr_r;
	assign mem_wdata = mem_wdata_r;
	assign transfer_modifier_code = tm_r;
	assign snp_ack = snp_ack_r;
	assign memory_response_inhibit = mi_r;
	assign snp_rdata = snp_rdata_r;

	// Moves a dirty line into the push buffer and frees its way
	task to_buffer;
		input [5:0] li;
		integer w;
		begin
			pb_vld_r  <= 1'b1;
			pb_addr_r <= {tag_r[li], li[5:2]};
			pb_fl_r   <= word_dirty_flags[li];
			for (w = 0; w < 4; w = w + 1)
				pb_dat_r[w] <= dat_r[li * 4 + w];
			lst_r[li]            <= `DCL_ST_INV;
			word_dirty_flags[li] <= 4'h0;
		end
	endtask

	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < 64; i = i + 1) begin
				lst_r[i]            <= `DCL_ST_INV;
				word_dirty_flags[i] <= 4'h0;
			end
			pb_vld_r    <= 1'b0;
			pb_addr_r   <= 28'h000_0000;
			pb_fl_r     <= 4'h0;
			st_r        <= S_IDLE;
			beat_r      <= 2'd0;
			slot_r      <= 2'd0;
			rq_addr_r   <= 32'h0000_0000;
			rq_data_r   <= 32'h0000_0000;
			rq_we_r     <= 1'b0;
			lfsr_r      <= `DCL_LFSR_SEED;
			hit_cnt_r   <= 32'h0000_0000;
			miss_cnt_r  <= 32'h0000_0000;
			iu_ack_r    <= 1'b0;
			iu_rdata_r  <= 32'h0000_0000;
			cmd_ack_r   <= 1'b0;
			mem_req_r   <= 1'b0;
			mem_we_r    <= 1'b0;
			mem_burst_r <= 1'b0;
			mem_addr_r  <= 32'h0000_0000;
			mem_wdata_r <= 32'h0000_0000;
			tm_r        <= `DCL_TM_DATA;
			snp_ack_r   <= 1'b0;
			mi_r        <= 1'b0;
			snp_rdata_r <= 32'h0000_0000;
		end else begin
			lfsr_r    <= lfsr_r[0] ? ((lfsr_r >> 1) ^ `DCL_LFSR_TAPS)
				: (lfsr_r >> 1);
			iu_ack_r  <= 1'b0;
			cmd_ack_r <= 1'b0;
			snp_ack_r <= 1'b0;
			mi_r      <= 1'b0;
			if (snp_go) begin
				snp_ack_r <= 1'b1;
				if (!snp_we && (sn_lv || sn_inv)) begin
					if (|sn_hit) begin
						if (sn_st == `DCL_ST_DRT) begin // see RQ14
							mi_r        <= 1'b1; // see RQ15
							snp_rdata_r <= dat_r[{sn_li, snp_addr[3:2]}];
						end
						if (sn_inv) begin
							lst_r[sn_li]            <= `DCL_ST_INV; // see RQ16
							word_dirty_flags[sn_li] <= 4'h0;
						end
					end else if (sn_pb) begin
						mi_r        <= 1'b1; // see RQ7
						snp_rdata_r <= pb_dat_r[snp_addr[3:2]];
						if (sn_inv)
							pb_vld_r <= 1'b0;
					end
				end else if (snp_we && (sn_lv || sn_inv)) begin
					if (|sn_hit) begin
						if (sn_lv && !snp_line && sn_st == `DCL_ST_DRT) begin
							mi_r <= 1'b1; // see RQ18
							dat_r[{sn_li, snp_addr[3:2]}] <= snp_wdata;
							word_dirty_flags[sn_li] <=
								word_dirty_flags[sn_li] | sn_bit;
						end else begin
							lst_r[sn_li]            <= `DCL_ST_INV; // see RQ17
							word_dirty_flags[sn_li] <= 4'h0;
						end
					end else if (sn_pb) begin
						if (sn_lv && !snp_line) begin
							mi_r <= 1'b1; // see RQ7
							pb_dat_r[snp_addr[3:2]] <= snp_wdata;
							pb_fl_r <= pb_fl_r | sn_bit;
						end else begin
							pb_vld_r <= 1'b0;
						end
					end
				end
			end
			case (st_r)
			S_IDLE: begin
				if (snp_go) begin
					st_r <= S_IDLE;
				end else if ((cache_invalidate_cmd || cache_writeback_cmd) &&
					!cmd_ack_r) begin
					cmd_ack_r <= 1'b1;
					if (|cm_hit) begin
						if (cache_writeback_cmd &&
							lst_r[cm_li] == `DCL_ST_DRT) begin
							to_buffer(cm_li); // see RQ13
							st_r <= S_PEND;
						end else begin
							lst_r[cm_li]            <= `DCL_ST_INV; // see RQ12
							word_dirty_flags[cm_li] <= 4'h0;
						end
					end
				end else if (iu_req && !iu_ack_r) begin
					rq_addr_r <= iu_addr;
					rq_data_r <= iu_wdata;
					rq_we_r   <= iu_we;
					beat_r    <= 2'd0;
					tm_r      <= `DCL_TM_DATA;
					if (!ctrl_en) begin
						mem_req_r   <= 1'b1;
						mem_we_r    <= iu_we;
						mem_burst_r <= 1'b0;
						mem_addr_r  <= iu_addr;
						mem_wdata_r <= iu_wdata;
						st_r        <= iu_we ? S_WT : S_RDMEM;
					end else if (|iu_hit) begin
						hit_cnt_r <= hit_cnt_r + 32'h0000_0001;
						if (!iu_we) begin
							iu_ack_r   <= 1'b1; // see RQ8
							iu_rdata_r <= dat_r[{iu_li, iu_addr[3:2]}];
						end else begin
							dat_r[{iu_li, iu_addr[3:2]}] <= iu_wdata;
							if (page_cache_mode) begin
								iu_ack_r <= 1'b1; // see RQ2
								word_dirty_flags[iu_li] <=
									word_dirty_flags[iu_li] | iu_bit; // see RQ10
								lst_r[iu_li] <= `DCL_ST_DRT;
							end else begin
								mem_req_r   <= 1'b1; // see RQ11
								mem_we_r    <= 1'b1;
								mem_burst_r <= 1'b0;
								mem_addr_r  <= iu_addr;
								mem_wdata_r <= iu_wdata;
								st_r        <= S_WT;
							end
						end
					end else begin
						miss_cnt_r <= miss_cnt_r + 32'h0000_0001;
						mem_req_r  <= 1'b1;
						if (iu_we && !page_cache_mode) begin
							mem_we_r    <= 1'b1; // see RQ9
							mem_burst_r <= 1'b0;
							mem_addr_r  <= iu_addr;
							mem_wdata_r <= iu_wdata;
							st_r        <= S_WT;
						end else begin
							mem_we_r    <= 1'b0; // see RQ3
							mem_burst_r <= 1'b1;
							mem_addr_r  <= {iu_addr[31:4], 4'h0};
							slot_r      <= vict;
							st_r        <= S_FILL;
							if (lst_r[v_li] == `DCL_ST_DRT)
								to_buffer(v_li); // see RQ6
							else
								lst_r[v_li] <= `DCL_ST_INV;
						end
					end
				end
			end
			S_FILL: begin
				if (mem_ack) begin
					if (rq_we_r && beat_r == rq_addr_r[3:2])
						dat_r[{fl_li, beat_r}] <= rq_data_r;
					else
						dat_r[{fl_li, beat_r}] <= mem_rdata;
					if (!rq_we_r && beat_r == rq_addr_r[3:2])
						iu_rdata_r <= mem_rdata;
					beat_r <= beat_r + 2'd1;
					if (beat_r == 2'd3) begin
						mem_req_r     <= 1'b0;
						iu_ack_r      <= 1'b1;
						tag_r[fl_li]  <= rq_addr_r[31:8];
						// see RQ5, see RQ20, see RQ1
						lst_r[fl_li]  <= rq_we_r ? `DCL_ST_DRT : `DCL_ST_VAL;
						word_dirty_flags[fl_li] <= rq_we_r ?
							(4'h1 << rq_addr_r[3:2]) : 4'h0; // see RQ10
						st_r <= pb_vld_r ? S_PEND : S_IDLE;
					end
				end
			end
			S_WT, S_RDMEM: begin
				if (mem_ack) begin
					mem_req_r <= 1'b0;
					if (st_r == S_RDMEM)
						iu_rdata_r <= mem_rdata;
					iu_ack_r <= 1'b1;
					st_r <= S_IDLE;
				end
			end
			S_PEND: begin
				// Buffered line stays snoopable until the push starts
				if (!pb_vld_r) begin
					st_r <= S_IDLE;
				end else if (!snp_go) begin
					mem_req_r <= 1'b1;
					mem_we_r  <= 1'b1;
					tm_r      <= `DCL_TM_PUSH; // see RQ22
					beat_r    <= 2'd0;
					st_r      <= S_PUSH;
					if (pb_multi) begin
						mem_burst_r <= 1'b1; // see RQ21
						mem_addr_r  <= {pb_addr_r, 4'h0};
						mem_wdata_r <= pb_dat_r[0];
					end else begin
						mem_burst_r <= 1'b0; // see RQ21
						mem_addr_r  <= {pb_addr_r, pb_one, 2'b00};
						mem_wdata_r <= pb_dat_r[pb_one];
					end
				end
			end
			S_PUSH: begin
				if (mem_ack) begin
					if (mem_burst_r && beat_r != 2'd3) begin
						beat_r      <= beat_r + 2'd1;
						mem_wdata_r <= pb_dat_r[beat_r + 2'd1];
					end else begin
						mem_req_r <= 1'b0;
						tm_r      <= `DCL_TM_DATA;
						pb_vld_r  <= 1'b0;
						st_r      <= S_IDLE;
					end
				end
			end
			default: begin
				st_r <= S_IDLE;
			end
			endcase
		end
	end

	dcl_axil u_regs (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.ctrl_en(ctrl_en), .busy(st_r != S_IDLE), .pb_held(pb_vld_r),
		.hit_cnt(hit_cnt_r), .miss_cnt(miss_cnt_r)
	);

endmodule

// >>> logic/dcl_consts.vh
// Purpose: Shared constants for the data cache line-state controller.
// Assumes: Included by every design file of the block.
// Notes:   Definitions only.
`ifndef DCL_CONSTS_VH
`define DCL_CONSTS_VH

// Register byte offsets
`define DCL_OFF_CTRL    12'h000
`define DCL_OFF_STATUS  12'h004
`define DCL_OFF_HITS    12'h008
`define DCL_OFF_MISSES  12'h00c

// Field positions and reset values
`define DCL_CTRL_EN      0
`define DCL_CTRL_EN_RST  1'b1

// Line states
`define DCL_ST_INV  2'h0
`define DCL_ST_VAL  2'h1
`define DCL_ST_DRT  2'h2

// Snoop control codes
`define DCL_SC_LEAVE  2'h1
`define DCL_SC_INVAL  2'h2

// Transfer modifier codes
`define DCL_TM_PUSH  3'h0
`define DCL_TM_DATA  3'h1

// Bus responses
`define DCL_RESP_OK   2'h0
`define DCL_RESP_ERR  2'h2

// Replacement generator
`define DCL_LFSR_SEED  8'h5a
`define DCL_LFSR_TAPS  8'hb8

`endif

// >>> logic/dcl_axil.v
// Purpose: AXI4-Lite register slave of the line-state controller.
// Assumes: One write and one read outstanding at most.
// Notes:   Unmapped offsets answer SLVERR; reads of them return zero.
`include "dcl_consts.vh"

module dcl_axil (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// Write channels
	input  wire        awvalid,
	output wire        awready,
	input  wire [11:0] awaddr,
	input  wire        wvalid,
	output wire        wready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	output wire        bvalid,
	input  wire        bready,
	output wire [1:0]  bresp,
	// Read channels
	input  wire        arvalid,
	output wire        arready,
	input  wire [11:0] araddr,
	output wire        rvalid,
	input  wire        rready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp,
	// Block side
	output wire        ctrl_en,
	input  wire        busy,
	input  wire        pb_held,
	input  wire [31:0] hit_cnt,
	input  wire [31:0] miss_cnt
);

	reg        aw_rdy_r;
	reg        w_rdy_r;
	reg        b_vld_r;
	reg        ar_rdy_r;
	reg        r_vld_r;
	reg [11:0] aw_a_r;
	reg [31:0] w_d_r;
	reg [3:0]  w_s_r;
	reg [1:0]  b_resp_r;
	reg [1:0]  r_resp_r;
	reg [31:0] r_d_r;
	reg        ctrl_en_r;

	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `DCL_OFF_CTRL) || (a == `DCL_OFF_STATUS) ||
				(a == `DCL_OFF_HITS) || (a == `DCL_OFF_MISSES);
		end
	endfunction

	assign awready = aw_rdy_r;
	assign wready  = w_rdy_r;
	assign bvalid  = b_vld_r;
	assign bresp   = b_resp_r;
	assign arready = ar_rdy_r;
	assign rvalid  = r_vld_r;
	assign rdata   = r_d_r;
	assign rresp   = r_resp_r;
	assign ctrl_en = ctrl_en_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_rdy_r  <= 1'b1;
			w_rdy_r   <= 1'b1;
			b_vld_r   <= 1'b0;
			ar_rdy_r  <= 1'b1;
			r_vld_r   <= 1'b0;
			aw_a_r    <= 12'h000;
			w_d_r     <= 32'h0000_0000;
			w_s_r     <= 4'h0;
			b_resp_r  <= `DCL_RESP_OK;
			r_resp_r  <= `DCL_RESP_OK;
			r_d_r     <= 32'h0000_0000;
			ctrl_en_r <= `DCL_CTRL_EN_RST;
		end else begin
			if (awvalid && aw_rdy_r) begin
				aw_a_r   <= awaddr;
				aw_rdy_r <= 1'b0;
			end
			if (wvalid && w_rdy_r) begin
				w_d_r   <= wdata;
				w_s_r   <= wstrb;
				w_rdy_r <= 1'b0;
			end
			// Both halves held: commit and answer
			if (!aw_rdy_r && !w_rdy_r && !b_vld_r) begin
				b_vld_r  <= 1'b1;
				b_resp_r <= mapped(aw_a_r) ? `DCL_RESP_OK : `DCL_RESP_ERR;
				if (aw_a_r == `DCL_OFF_CTRL && w_s_r[0])
					ctrl_en_r <= w_d_r[`DCL_CTRL_EN];
			end
			if (b_vld_r && bready) begin
				b_vld_r  <= 1'b0;
				aw_rdy_r <= 1'b1;
				w_rdy_r  <= 1'b1;
			end
			if (arvalid && ar_rdy_r) begin
				ar_rdy_r <= 1'b0;
				r_vld_r  <= 1'b1;
				r_resp_r <= mapped(araddr) ? `DCL_RESP_OK : `DCL_RESP_ERR;
				case (araddr)
				`DCL_OFF_CTRL:   r_d_r <= {31'h0, ctrl_en_r};
				`DCL_OFF_STATUS: r_d_r <= {30'h0, pb_held, busy};
				`DCL_OFF_HITS:   r_d_r <= hit_cnt;
				`DCL_OFF_MISSES: r_d_r <= miss_cnt;
				default:         r_d_r <= 32'h0000_0000;
				endcase
			end
			if (r_vld_r && rready) begin
				r_vld_r  <= 1'b0;
				ar_rdy_r <= 1'b1;
			end
		end
	end

endmodule

// >>> dv/dcl_line_ctrl_assertions.sv
// Purpose: Port-level checks of the line-state controller.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into every instance of the top module.
module dcl_lc_chk (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Commands and memory bus
	input wire        cache_invalidate_cmd,
	input wire        cache_writeback_cmd,
	input wire        cmd_ack,
	input wire        mem_req,
	input wire        mem_we,
	input wire        mem_burst,
	input wire [31:0] mem_addr,
	input wire [2:0]  transfer_modifier_code,
	input wire        mem_ack,
	// Snoop port
	input wire        snp_valid,
	input wire        snp_we,
	input wire        snp_line,
	input wire [1:0]  snoop_control_code,
	input wire        snp_ack,
	input wire        memory_response_inhibit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] beats_r;
	always @(posedge aclk)
		if (!aresetn || !mem_req) beats_r <= 3'h0;
		else if (mem_ack) beats_r <= beats_r + 3'h1;
	snoop_answer_a: assert property (
		$rose(snp_valid) |-> ##[1:300] snp_ack) else $error("snoop unanswered");
	burst_base_a: assert property (
		$rose(mem_req) && mem_burst |-> mem_addr[3:0] == 4'h0)
		else $error("burst not line aligned");
	hold_req_a: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("bus request dropped early");
	push_code_a: assert property (
		mem_req && mem_we && mem_burst |-> transfer_modifier_code == 3'h0)
		else $error("line push without push code");
	fill_code_a: assert property (
		mem_req && !mem_we |-> transfer_modifier_code == 3'h1)
		else $error("read with push code");
	inv_quiet_a: assert property (
		cmd_ack && cache_invalidate_cmd |=> !mem_req)
		else $error("invalidate touched memory");
	push_cmd_a: assert property (
		cmd_ack && cache_writeback_cmd ##1 mem_req |->
		mem_we && transfer_modifier_code == 3'h0) else $error("bad push");
	inhibit_ack_a: assert property (
		memory_response_inhibit |-> snp_ack &&
		snoop_control_code inside {2'h1, 2'h2}) else $error("stray inhibit");
	snoop_inval_a: assert property (
		snp_ack && snp_we && (snoop_control_code == 2'h2 || snp_line)
		|-> !memory_response_inhibit) else $error("write sunk wrongly");
	burst_end_a: assert property (
		$fell(mem_req) && $past(mem_burst) |-> beats_r == 3'h4)
		else $error("burst not four beats");
	cover property (memory_response_inhibit && !snp_we);
	cover property (mem_req && mem_we && mem_burst);
	cover property (cmd_ack && cache_writeback_cmd);
endmodule

bind dcl_line_ctrl dcl_lc_chk u_chk (.aclk, .aresetn, .cache_invalidate_cmd,
	.cache_writeback_cmd, .cmd_ack, .mem_req, .mem_we, .mem_burst, .mem_addr,
	.transfer_modifier_code, .mem_ack, .snp_valid, .snp_we, .snp_line,
	.snoop_control_code, .snp_ack, .memory_response_inhibit);

// >>> dv/dcl_mem_model.sv
// Purpose: Memory partner answering fills and write-backs.
// Assumes: One transfer at a time, beats acknowledged in order.
// Notes:   Read data is a pattern of the address; writes are logged.
module dcl_mem_model (
	// Clock and reset
	input  wire         aclk,
	input  wire         aresetn,
	// Bus from the controller
	input  wire         mem_req,
	input  wire         mem_we,
	input  wire [31:0]  mem_addr,
	input  wire [31:0]  mem_wdata,
	input  wire [2:0]   transfer_modifier_code,
	output logic        mem_ack,
	output logic [31:0] mem_rdata,
	// Wait states per beat
	input  wire [3:0]   dly
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  cnt;
	logic [1:0]  beat;
	logic [31:0] wa;
	logic [31:0] wd;
	logic [2:0]  wtm;
	int          fills = 0;
	int          wrs = 0;
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		// Released data toggles every cycle, so it shows the last beat every other cycle
		mem_rdata <= ~mem_rdata;
		if (!aresetn) begin
			mem_rdata <= 32'h0000_0000;
			cnt <= 4'h0;
			beat <= 2'h0;
		end else if (!mem_req) begin
			cnt <= 4'h0;
			beat <= 2'h0;
		end else if (!mem_ack) begin
			if (cnt < dly) cnt <= cnt + 4'h1;
			else begin
				mem_ack <= 1'b1;
				cnt <= 4'h0;
				beat <= beat + 2'h1;
				mem_rdata <= pat(mem_addr + {beat, 2'b00});
				if (!mem_we && beat == 2'h0) fills++;
				if (mem_we) wrs++;
				if (mem_we && beat == 2'h0) begin
					wa <= mem_addr;
					wd <= mem_wdata;
					wtm <= transfer_modifier_code;
				end
			end
		end
	end
endmodule

// >>> dv/data_cache_line_state_control_tb.sv
// Purpose: Self-checking bench of the line-state controller.
// Assumes: Memory partner answers every beat; no bus errors.
// Notes:   Scenarios run in sequence after one reset.
module data_cache_line_state_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A2 = 32'h0000_2064, A3 = 32'h0000_3074;
	localparam logic [31:0] A4 = 32'h0000_4080, A5 = 32'h0000_5090;
	localparam logic [31:0] AR = 32'h0001_00a4, A6 = 32'h0000_60b0;
	logic aclk = 0, aresetn = 0, iu_req = 0, iu_we = 0, page_cache_mode = 0;
	logic [31:0] iu_addr = '0, iu_wdata = '0, cmd_addr = '0, d;
	logic cache_invalidate_cmd = 0, cache_writeback_cmd = 0;
	logic snp_valid = 0, snp_we = 0, snp_line = 0;
	logic [1:0] snoop_control_code = '0, r;
	logic [31:0] snp_addr = '0, snp_wdata = '0, wdata = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [3:0] wstrb = 4'hf, dly = 4'h0;
	wire iu_ack, cmd_ack, mem_req, mem_we, mem_burst, mem_ack, snp_ack;
	wire memory_response_inhibit, awready, wready, bvalid, arready, rvalid;
	wire [31:0] iu_rdata, mem_addr, mem_wdata, mem_rdata, snp_rdata, rdata;
	wire [2:0] transfer_modifier_code;
	wire [1:0] bresp, rresp;
	int n_errors = 0, samples_checked = 0;
	always #12.5 aclk = ~aclk;
	dcl_line_ctrl u_dut (.aclk, .aresetn, .iu_req, .iu_we, .iu_addr,
		.iu_wdata, .page_cache_mode, .iu_ack, .iu_rdata,
		.cache_invalidate_cmd, .cache_writeback_cmd, .cmd_addr, .cmd_ack,
		.mem_req, .mem_we, .mem_burst, .mem_addr, .mem_wdata,
		.transfer_modifier_code, .mem_ack, .mem_rdata, .snp_valid, .snp_we,
		.snp_line, .snoop_control_code, .snp_addr, .snp_wdata, .snp_ack,
		.memory_response_inhibit, .snp_rdata, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	dcl_mem_model u_mem (.aclk, .aresetn, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .transfer_modifier_code, .mem_ack, .mem_rdata, .dly);
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= v;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1);
		r = bresp;
		bready <= 0;
	endtask
	task automatic axr(input logic [11:0] a);
		@(posedge aclk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task automatic idle;
		do axr(12'h004); while (d[1:0] !== 2'h0);
	endtask
	task automatic iu(input logic w, input logic [31:0] a, v, input logic cm);
		@(posedge aclk);
		iu_req <= 1;
		iu_we <= w;
		iu_addr <= a;
		iu_wdata <= v;
		page_cache_mode <= cm;
		do @(posedge aclk); while (iu_ack !== 1);
		d = iu_rdata;
		iu_req <= 0;
	endtask
	task automatic rd(input logic [31:0] a, e, input int df);
		int f = u_mem.fills;
		iu(1'b0, a, 32'h0, 1'b1);
		chk("read data", e, d);
		chk("fills", f + df, u_mem.fills);
	endtask
	task automatic wr(input logic [31:0] a, v, input logic cm, input int df, dw);
		int f = u_mem.fills, w = u_mem.wrs;
		iu(1'b1, a, v, cm);
		chk("fills", f + df, u_mem.fills);
		chk("writes", w + dw, u_mem.wrs);
	endtask
	task automatic wchk(input int w0, n, input logic [31:0] a, v);
		chk("writes", w0 + n, u_mem.wrs);
		chk("wr addr", a, u_mem.wa);
		chk("wr data", v, u_mem.wd);
		chk("tm", 32'h0, u_mem.wtm);
	endtask
	task automatic snp(input logic w, ln, input logic [1:0] c,
		input logic [31:0] a, v, input logic em, input logic [31:0] ed);
		@(posedge aclk);
		snp_valid <= 1;
		snp_we <= w;
		snp_line <= ln;
		snoop_control_code <= c;
		snp_addr <= a;
		snp_wdata <= v;
		do @(posedge aclk); while (snp_ack !== 1);
		chk("inhibit", em, memory_response_inhibit);
		if (em && !w) chk("snoop data", ed, snp_rdata);
		snp_valid <= 0;
	endtask
	task automatic cmd(input logic p, input logic [31:0] a);
		@(posedge aclk);
		cache_writeback_cmd <= p;
		cache_invalidate_cmd <= !p;
		cmd_addr <= a;
		do @(posedge aclk); while (cmd_ack !== 1);
		cache_writeback_cmd <= 0;
		cache_invalidate_cmd <= 0;
		idle;
	endtask
	task automatic t_regs;
		axr(12'h000);
		chk("ctrl", 32'h1, d);
		axr(12'h004);
		chk("status", 32'h0, d);
		axr(12'h010);
		chk("rresp", 32'h2, r);
		chk("rdata", 32'h0, d);
		axw(12'h008, 32'h0000_00ff);
		chk("bresp", 32'h0, r);
		axw(12'h020, 32'h0000_0001);
		chk("bresp", 32'h2, r);
	endtask
	task automatic t_read;
		dly <= 4'h2;
		rd(32'h0000_1058, u_mem.pat(32'h0000_1058), 1);
		rd(32'h0000_1058, u_mem.pat(32'h0000_1058), 0);
		axr(12'h008);
		chk("hits", 32'h1, d);
		axr(12'h00c);
		chk("misses", 32'h1, d);
	endtask
	task automatic t_wr;
		dly <= 4'h0;
		wr(A2, 32'h1111_2222, 1, 1, 0);
		// Clean lines only
		wr(A3, 32'h3333_4444, 0, 0, 1);
		chk("tm", 32'h1, u_mem.wtm);
		rd(A3, u_mem.pat(A3), 1);
		wr(A3, 32'h5555_6666, 0, 0, 1);
		rd(A3, 32'h5555_6666, 0);
		rd(A2, 32'h1111_2222, 0);
	endtask
	task automatic t_snoop;
		snp(0, 0, 2'h1, A2, 0, 1, 32'h1111_2222);
		snp(0, 0, 2'h1, A3, 0, 0, 0);
		snp(0, 0, 2'h0, A3, 0, 0, 0);
		snp(1, 0, 2'h3, A3, 1, 0, 0);
		rd(A3, 32'h5555_6666, 0);
		snp(1, 0, 2'h1, A2, 32'h7777_8888, 1, 0);
		rd(A2, 32'h7777_8888, 0);
		snp(0, 0, 2'h2, A2, 0, 1, 32'h7777_8888);
		rd(A2, u_mem.pat(A2), 1);
		snp(1, 0, 2'h2, A3, 1, 0, 0);
		rd(A3, u_mem.pat(A3), 1);
		snp(1, 1, 2'h1, A3, 1, 0, 0);
		rd(A3, u_mem.pat(A3), 1);
	endtask
	task automatic t_cmd;
		int w;
		wr(A4, 32'h9999_aaaa, 1, 1, 0);
		w = u_mem.wrs;
		cmd(0, A4);
		chk("writes", w, u_mem.wrs);
		rd(A4, u_mem.pat(A4), 1);
		wr(A4, 32'h9999_aaaa, 1, 0, 0);
		cmd(1, A4);
		wchk(w, 1, A4, 32'h9999_aaaa);
		rd(A4, u_mem.pat(A4), 1);
		wr(A5, 32'hbbbb_cccc, 1, 1, 0);
		wr(A5 + 8, 32'hdddd_eeee, 1, 0, 0);
		cmd(1, A5);
		wchk(w + 1, 4, A5, 32'hbbbb_cccc);
		cmd(1, A3);
		chk("writes", w + 5, u_mem.wrs);
		rd(A3, u_mem.pat(A3), 1);
	endtask
	task automatic t_repl;
		int k, w;
		dly <= 4'h1;
		for (k = 0; k < 4; k++)
			wr(AR + (k << 12), k, 1, 1, 0);
		for (k = 0; k < 4; k++)
			rd(AR + (k << 12), k, 0);
		w = u_mem.wrs;
		wr(AR + 32'h4000, 32'h0123_4567, 1, 1, 0);
		idle;
		chk("writes", w + 1, u_mem.wrs);
		chk("victim", AR + {u_mem.wd[1:0], 12'h000}, u_mem.wa);
		chk("tm", 32'h0, u_mem.wtm);
		rd(AR + 32'h4000, 32'h0123_4567, 0);
	endtask
	task automatic t_off;
		axw(12'h000, 32'h0000_0000);
		rd(A6, u_mem.pat(A6), 1);
		rd(A6, u_mem.pat(A6), 1);
		axw(12'h000, 32'h0000_0001);
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_read;
		t_wr;
		t_snoop;
		t_cmd;
		t_repl;
		t_off;
		print_verdict;
	end
	initial begin
		#(25 * 40000);
		n_errors++;
		print_verdict;
	end
endmodule
